// ==== pkg/ued_params.svh ====
// register offsets, field positions and reset values of the uart event bank
`ifndef UED_PARAMS_SVH
`define UED_PARAMS_SVH
`define UED_NEV 11
`define UED_NCH 16
`define UED_EV_CTS_LOW_OFF 12'h100
`define UED_EV_CTS_HIGH_OFF 12'h104
`define UED_EV_RX_RDY_OFF 12'h108
`define UED_EV_RX_FULL_OFF 12'h110
`define UED_EV_TX_SENT_OFF 12'h11c
`define UED_EV_TX_DONE_OFF 12'h120
`define UED_EV_FAULT_OFF 12'h124
`define UED_EV_RX_TMO_OFF 12'h144
`define UED_EV_RX_BEG_OFF 12'h14c
`define UED_EV_TX_BEG_OFF 12'h150
`define UED_EV_TX_HALT_OFF 12'h158
`define UED_PUB_CTS_LOW_OFF 12'h180
`define UED_PUB_CTS_HIGH_OFF 12'h184
`define UED_PUB_RX_RDY_OFF 12'h188
`define UED_PUB_RX_FULL_OFF 12'h190
`define UED_PUB_TX_SENT_OFF 12'h19c
`define UED_PUB_TX_DONE_OFF 12'h1a0
`define UED_PUB_FAULT_OFF 12'h1a4
`define UED_PUB_RX_TMO_OFF 12'h1c4
`define UED_PUB_RX_BEG_OFF 12'h1cc
`define UED_PUB_TX_BEG_OFF 12'h1d0
`define UED_PUB_TX_HALT_OFF 12'h1d8
`define UED_SHORTCUT_OFF 12'h200
`define UED_IEN_OFF 12'h300
`define UED_IEN_SET_OFF 12'h304
`define UED_IEN_CLR_OFF 12'h308
`define UED_SUMMARY_OFF 12'h310
`define UED_IEN_CTS_LOW_BIT 0
`define UED_IEN_CTS_HIGH_BIT 1
`define UED_IEN_RX_RDY_BIT 2
`define UED_IEN_RX_FULL_BIT 4
`define UED_IEN_TX_SENT_BIT 7
`define UED_IEN_TX_DONE_BIT 8
`define UED_IEN_FAULT_BIT 9
`define UED_IEN_RX_TMO_BIT 17
`define UED_IEN_RX_BEG_BIT 19
`define UED_IEN_TX_BEG_BIT 20
`define UED_IEN_TX_HALT_BIT 22
`define UED_IEN_MASK 32'h005a_0397
`define UED_EV_FLAG_BIT 0
`define UED_PUB_EN_BIT 31
`define UED_PUB_CH_LSB 0
`define UED_PUB_CH_W 4
`define UED_SC_BEGIN_BIT 0
`define UED_SC_HALT_BIT 1
`define UED_SC_MASK 32'h0000_0003
`define UED_REG_RST 32'h0000_0000
`define UED_CTS_IDLE 1'b1
`define UED_RESP_OKAY 2'h0
`define UED_RESP_SLVERR 2'h2
`endif

// ==== pkg/ued_pkg.sv ====
// shared types of the uart event register bank
`include "ued_params.svh"
package ued_pkg;
  typedef enum logic [3:0] {
    EV_CTS_LOW, EV_CTS_HIGH, EV_RX_RDY, EV_RX_FULL, EV_TX_SENT, EV_TX_DONE,
    EV_FAULT, EV_RX_TMO, EV_RX_BEG, EV_TX_BEG, EV_TX_HALT
  } ued_ev_e;
  typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} ued_wr_e;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} ued_rd_e;
  typedef logic [`UED_NCH-1:0] ued_chan_t;
  typedef logic [`UED_NEV-1:0] ued_evvec_t;
  typedef logic [11:0] ued_addr_t;
  typedef struct packed {
    logic flag;
    logic en;
    logic [`UED_PUB_CH_W-1:0] channel_index;
  } ued_slot_s;
  typedef struct packed {
    ued_wr_e wr;
    ued_rd_e rd;
    logic aw_got;
    logic w_got;
    ued_addr_t waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] irq_enable;
    logic [31:0] shortcut;
    logic cts_prev;
    ued_chan_t pub;
    logic begin_t;
    logic halt_t;
    logic irq;
  } ued_state_s;
endpackage : ued_pkg

// ==== pkg/ued_slot_if.sv ====
// link between the register bank and one event slot
`timescale 1ns/1ns
interface ued_slot_if;
  logic set;
  logic flag_we;
  logic flag_wd;
  logic cfg_we;
  logic [31:0] cfg_wd;
  logic rd_clr;
  logic flag;
  logic [31:0] cfg_rd;
  ued_pkg::ued_chan_t chan;
  modport slot (input set, flag_we, flag_wd, cfg_we, cfg_wd, rd_clr,
                output flag, cfg_rd, chan);
  modport bank (output set, flag_we, flag_wd, cfg_we, cfg_wd, rd_clr,
                input flag, cfg_rd, chan);
endinterface : ued_slot_if

// ==== src/ued_evt_slot.sv ====
// one event: sticky flag plus its publish configuration
`timescale 1ns/1ns
`include "ued_params.svh"
module ued_evt_slot (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link to the register bank
  ued_slot_if.slot s
);
  import ued_pkg::*;

  localparam ued_slot_s SLOT_RST = '{flag: 1'b0, en: 1'b0, channel_index: '0};
  ued_slot_s st_r;
  ued_slot_s st_nxt;

  // next state; a new occurrence beats both ways of clearing
  always_comb
  begin
    st_nxt = st_r;
    if (s.cfg_we)
    begin
      st_nxt.en = s.cfg_wd[`UED_PUB_EN_BIT];
      st_nxt.channel_index = s.cfg_wd[`UED_PUB_CH_LSB +: `UED_PUB_CH_W];
    end
    if (s.set)
      st_nxt.flag = 1'b1;
    else if (s.rd_clr)
      st_nxt.flag = 1'b0;
    else if (s.flag_we)
      st_nxt.flag = s.flag_wd;
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= SLOT_RST;
    else
      st_r <= st_nxt;
  end

  // read view of the publish register
  always_comb
  begin
    s.cfg_rd = '0;
    s.cfg_rd[`UED_PUB_EN_BIT] = st_r.en;
    s.cfg_rd[`UED_PUB_CH_LSB +: `UED_PUB_CH_W] = st_r.channel_index;
  end

  assign s.flag = st_r.flag;
  // broadcast uses the configuration in force when the event fires
  assign s.chan = (s.set && st_r.en) ? (ued_chan_t'(16'h0001) << st_r.channel_index) : '0;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  set_wins_a: assert property (s.set |=> s.flag)
    else $error("event lost against a clear");
  flag_hold_a: assert property (!s.set && !s.rd_clr && !s.flag_we |=> $stable(s.flag))
    else $error("flag changed without cause");
  pub_chan_a: assert property (s.set && st_r.en |-> $onehot(s.chan) && s.chan[st_r.channel_index])
    else $error("event broadcast on wrong channel");
  pub_off_a: assert property (s.cfg_we && !s.cfg_wd[`UED_PUB_EN_BIT] |=> s.chan == '0)
    else $error("disabled event still broadcast");
  cfg_load_a: assert property (s.cfg_we |=> s.cfg_rd == $past(s.cfg_wd & 32'h8000_000f))
    else $error("publish config not loaded");
endmodule : ued_evt_slot

// ==== src/ued_event_regs.sv ====
// uart event, publish, shortcut and interrupt-enable register bank
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "ued_params.svh"
module ued_event_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire ued_pkg::ued_addr_t s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire ued_pkg::ued_addr_t s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // event pulses from the serial engine and dma
  input wire logic rx_byte_ready_ev,
  input wire logic rx_buffer_full_ev,
  input wire logic tx_byte_sent_ev,
  input wire logic tx_done_ev,
  input wire logic fault_ev,
  input wire logic rx_timeout_ev,
  input wire logic rx_begun_ev,
  input wire logic tx_begun_ev,
  input wire logic tx_halted_ev,
  // flow-control pin, low means clear to send
  input wire logic flow_ctrl_n,
  // broadcast channels, shortcut tasks and interrupt
  output ued_pkg::ued_chan_t pub_chan,
  output logic rx_begin_task,
  output logic rx_halt_task,
  output logic irq
);
  import ued_pkg::*;

  localparam ued_state_s RST = '{wr: WR_COLLECT, rd: RD_IDLE, cts_prev: `UED_CTS_IDLE,
                                 irq_enable: `UED_REG_RST, shortcut: `UED_REG_RST, default: '0};

  // flag register offset of each event
  function automatic ued_addr_t evt_off(input int i);
    case (i)
      EV_CTS_LOW: evt_off = `UED_EV_CTS_LOW_OFF;
      EV_CTS_HIGH: evt_off = `UED_EV_CTS_HIGH_OFF;
      EV_RX_RDY: evt_off = `UED_EV_RX_RDY_OFF;
      EV_RX_FULL: evt_off = `UED_EV_RX_FULL_OFF;
      EV_TX_SENT: evt_off = `UED_EV_TX_SENT_OFF;
      EV_TX_DONE: evt_off = `UED_EV_TX_DONE_OFF;
      EV_FAULT: evt_off = `UED_EV_FAULT_OFF;
      EV_RX_TMO: evt_off = `UED_EV_RX_TMO_OFF;
      EV_RX_BEG: evt_off = `UED_EV_RX_BEG_OFF;
      EV_TX_BEG: evt_off = `UED_EV_TX_BEG_OFF;
      default: evt_off = `UED_EV_TX_HALT_OFF;
    endcase
  endfunction : evt_off

  // publish register offset of each event
  function automatic ued_addr_t pub_off(input int i);
    case (i)
      EV_CTS_LOW: pub_off = `UED_PUB_CTS_LOW_OFF;
      EV_CTS_HIGH: pub_off = `UED_PUB_CTS_HIGH_OFF;
      EV_RX_RDY: pub_off = `UED_PUB_RX_RDY_OFF;
      EV_RX_FULL: pub_off = `UED_PUB_RX_FULL_OFF;
      EV_TX_SENT: pub_off = `UED_PUB_TX_SENT_OFF;
      EV_TX_DONE: pub_off = `UED_PUB_TX_DONE_OFF;
      EV_FAULT: pub_off = `UED_PUB_FAULT_OFF;
      EV_RX_TMO: pub_off = `UED_PUB_RX_TMO_OFF;
      EV_RX_BEG: pub_off = `UED_PUB_RX_BEG_OFF;
      EV_TX_BEG: pub_off = `UED_PUB_TX_BEG_OFF;
      default: pub_off = `UED_PUB_TX_HALT_OFF;
    endcase
  endfunction : pub_off

  // position of each event in the enable and summary layout
  function automatic int ien_bit(input int i);
    case (i)
      EV_CTS_LOW: ien_bit = `UED_IEN_CTS_LOW_BIT;
      EV_CTS_HIGH: ien_bit = `UED_IEN_CTS_HIGH_BIT;
      EV_RX_RDY: ien_bit = `UED_IEN_RX_RDY_BIT;
      EV_RX_FULL: ien_bit = `UED_IEN_RX_FULL_BIT;
      EV_TX_SENT: ien_bit = `UED_IEN_TX_SENT_BIT;
      EV_TX_DONE: ien_bit = `UED_IEN_TX_DONE_BIT;
      EV_FAULT: ien_bit = `UED_IEN_FAULT_BIT;
      EV_RX_TMO: ien_bit = `UED_IEN_RX_TMO_BIT;
      EV_RX_BEG: ien_bit = `UED_IEN_RX_BEG_BIT;
      EV_TX_BEG: ien_bit = `UED_IEN_TX_BEG_BIT;
      default: ien_bit = `UED_IEN_TX_HALT_BIT;
    endcase
  endfunction : ien_bit

  ued_state_s st_r;
  ued_state_s st_nxt;
  ued_slot_if sif [`UED_NEV] ();
  ued_evvec_t ev;
  ued_evvec_t flag_v;
  ued_evvec_t ien_v;
  ued_evvec_t flag_we_v;
  ued_evvec_t cfg_we_v;
  ued_evvec_t rd_clr_v;
  logic [31:0] cfg_rd_a [`UED_NEV];
  ued_chan_t chan_a [`UED_NEV];
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic wr_ok;
  logic rd_ok;
  ued_addr_t w_a;
  logic [31:0] w_d;
  logic [31:0] w_m;
  logic [31:0] wmd;
  logic [31:0] rd_val;
  logic [31:0] summary;

  // event sources; the pin edges come from last cycle's sample
  assign ev[EV_CTS_LOW] = st_r.cts_prev && !flow_ctrl_n;
  assign ev[EV_CTS_HIGH] = !st_r.cts_prev && flow_ctrl_n;
  assign ev[EV_RX_RDY] = rx_byte_ready_ev;
  assign ev[EV_RX_FULL] = rx_buffer_full_ev;
  assign ev[EV_TX_SENT] = tx_byte_sent_ev;
  assign ev[EV_TX_DONE] = tx_done_ev;
  assign ev[EV_FAULT] = fault_ev;
  assign ev[EV_RX_TMO] = rx_timeout_ev;
  assign ev[EV_RX_BEG] = rx_begun_ev;
  assign ev[EV_TX_BEG] = tx_begun_ev;
  assign ev[EV_TX_HALT] = tx_halted_ev;

  // one slot per event
  for (genvar i = 0; i < `UED_NEV; i++)
  begin : g_slot
    ued_evt_slot u_slot (
      .aclk(aclk),
      .aresetn(aresetn),
      .s(sif[i])
    );
    assign sif[i].set = ev[i];
    assign sif[i].flag_we = flag_we_v[i];
    assign sif[i].flag_wd = w_d[`UED_EV_FLAG_BIT];
    assign sif[i].cfg_we = cfg_we_v[i];
    assign sif[i].cfg_wd = (sif[i].cfg_rd & ~w_m) | wmd;
    assign sif[i].rd_clr = rd_clr_v[i];
    assign flag_v[i] = sif[i].flag;
    assign cfg_rd_a[i] = sif[i].cfg_rd;
    assign chan_a[i] = sif[i].chan;
    assign ien_v[i] = st_r.irq_enable[ien_bit(i)];
  end

  // bus handshakes; address and data may arrive in either order
  assign s_axi_awready = (st_r.wr == WR_COLLECT) && !st_r.aw_got;
  assign s_axi_wready = (st_r.wr == WR_COLLECT) && !st_r.w_got;
  assign s_axi_arready = (st_r.rd == RD_IDLE);
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wr_fire = (st_r.wr == WR_COLLECT) && (st_r.aw_got || aw_hs) && (st_r.w_got || w_hs);
  assign w_a = st_r.aw_got ? st_r.waddr : s_axi_awaddr;
  assign w_d = st_r.w_got ? st_r.wdata : s_axi_wdata;
  assign wmd = w_d & w_m;

  // address decode for both directions
  always_comb
  begin
    logic [3:0] strb;
    strb = st_r.w_got ? st_r.wstrb : s_axi_wstrb;
    for (int b = 0; b < 4; b++)
      w_m[b*8 +: 8] = {8{strb[b]}};
    flag_we_v = '0;
    cfg_we_v = '0;
    rd_clr_v = '0;
    summary = '0;
    rd_val = '0;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    for (int i = 0; i < `UED_NEV; i++)
    begin
      summary[ien_bit(i)] = flag_v[i];
      if (w_a == evt_off(i))
      begin
        flag_we_v[i] = wr_fire && w_m[`UED_EV_FLAG_BIT];
        wr_ok = 1'b1;
      end
      if (w_a == pub_off(i))
      begin
        cfg_we_v[i] = wr_fire;
        wr_ok = 1'b1;
      end
      if (s_axi_araddr == evt_off(i))
      begin
        rd_val[`UED_EV_FLAG_BIT] = flag_v[i];
        rd_ok = 1'b1;
      end
      if (s_axi_araddr == pub_off(i))
      begin
        rd_val = cfg_rd_a[i];
        rd_ok = 1'b1;
      end
    end
    if (w_a inside {`UED_SHORTCUT_OFF, `UED_IEN_OFF, `UED_IEN_SET_OFF,
                    `UED_IEN_CLR_OFF, `UED_SUMMARY_OFF})
      wr_ok = 1'b1;
    if (s_axi_araddr == `UED_SHORTCUT_OFF)
    begin
      rd_val = st_r.shortcut;
      rd_ok = 1'b1;
    end
    if (s_axi_araddr inside {`UED_IEN_OFF, `UED_IEN_SET_OFF, `UED_IEN_CLR_OFF})
    begin
      rd_val = st_r.irq_enable;
      rd_ok = 1'b1;
    end
    if (s_axi_araddr == `UED_SUMMARY_OFF)
    begin
      // reading the summary clears what it reports; a new event still wins
      rd_val = summary;
      rd_ok = 1'b1;
      rd_clr_v = {`UED_NEV{ar_hs}};
    end
  end

  // next state of the bank
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.cts_prev = flow_ctrl_n;
    st_nxt.pub = '0;
    for (int i = 0; i < `UED_NEV; i++)
      st_nxt.pub = st_nxt.pub | chan_a[i];
    st_nxt.begin_t = rx_buffer_full_ev && st_r.shortcut[`UED_SC_BEGIN_BIT];
    st_nxt.halt_t = rx_buffer_full_ev && st_r.shortcut[`UED_SC_HALT_BIT];
    st_nxt.irq = |(flag_v & ien_v);
    unique case (st_r.wr)
      WR_COLLECT:
      begin
        if (aw_hs)
        begin
          st_nxt.aw_got = 1'b1;
          st_nxt.waddr = s_axi_awaddr;
        end
        if (w_hs)
        begin
          st_nxt.w_got = 1'b1;
          st_nxt.wdata = s_axi_wdata;
          st_nxt.wstrb = s_axi_wstrb;
        end
        if (wr_fire)
        begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got = 1'b0;
          st_nxt.wr = WR_RESP;
          st_nxt.bresp = wr_ok ? `UED_RESP_OKAY : `UED_RESP_SLVERR;
          if (w_a == `UED_IEN_OFF)
            st_nxt.irq_enable = ((st_r.irq_enable & ~w_m) | wmd) & `UED_IEN_MASK;
          if (w_a == `UED_IEN_SET_OFF)
            st_nxt.irq_enable = (st_r.irq_enable | wmd) & `UED_IEN_MASK;
          if (w_a == `UED_IEN_CLR_OFF)
            st_nxt.irq_enable = st_r.irq_enable & ~wmd;
          if (w_a == `UED_SHORTCUT_OFF)
            st_nxt.shortcut = ((st_r.shortcut & ~w_m) | wmd) & `UED_SC_MASK;
        end
      end
      WR_RESP:
      begin
        if (s_axi_bready)
          st_nxt.wr = WR_COLLECT;
      end
    endcase
    unique case (st_r.rd)
      RD_IDLE:
      begin
        if (ar_hs)
        begin
          st_nxt.rd = RD_RESP;
          st_nxt.rdata = rd_val;
          st_nxt.rresp = rd_ok ? `UED_RESP_OKAY : `UED_RESP_SLVERR;
        end
      end
      RD_RESP:
      begin
        if (s_axi_rready)
          st_nxt.rd = RD_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= RST;
    else
      st_r <= st_nxt;
  end

  // outputs, all from the state register
  assign s_axi_bvalid = (st_r.wr == WR_RESP);
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = (st_r.rd == RD_RESP);
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign pub_chan = st_r.pub;
  assign rx_begin_task = st_r.begin_t;
  assign rx_halt_task = st_r.halt_t;
  assign irq = st_r.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ien_set_s;
    wr_fire && (w_a == `UED_IEN_SET_OFF);
  endsequence
  sequence ien_clr_s;
    wr_fire && (w_a == `UED_IEN_CLR_OFF);
  endsequence
  sequence wr_done_s;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence

  rx_ready_flag_a: assert property (rx_byte_ready_ev |=> flag_v[EV_RX_RDY])
    else $error("received-byte flag not set");
  full_flag_a: assert property (rx_buffer_full_ev |=> flag_v[EV_RX_FULL])
    else $error("buffer-full flag not set");
  tx_sent_flag_a: assert property (tx_byte_sent_ev |=> flag_v[EV_TX_SENT])
    else $error("byte-sent flag not set");
  tx_done_flag_a: assert property (tx_done_ev |=> flag_v[EV_TX_DONE])
    else $error("transmit-done flag not set");
  rx_begun_flag_a: assert property (rx_begun_ev |=> flag_v[EV_RX_BEG])
    else $error("receiver-started flag not set");
  tx_begun_flag_a: assert property (tx_begun_ev |=> flag_v[EV_TX_BEG])
    else $error("transmitter-started flag not set");
  cts_low_a: assert property ($fell(flow_ctrl_n) |=> flag_v[EV_CTS_LOW])
    else $error("clear-to-send event missed");
  cts_high_a: assert property ($rose(flow_ctrl_n) |=> flag_v[EV_CTS_HIGH])
    else $error("not-clear-to-send event missed");
  short_begin_a: assert property (rx_buffer_full_ev && st_r.shortcut[`UED_SC_BEGIN_BIT]
                                  |=> rx_begin_task ##1 !rx_begin_task || $past(rx_buffer_full_ev))
    else $error("receive-start shortcut not fired");
  short_halt_a: assert property (!(rx_buffer_full_ev && st_r.shortcut[`UED_SC_HALT_BIT])
                                 |=> !rx_halt_task)
    else $error("receive-stop fired without shortcut");
  irq_level_a: assert property (|(flag_v & ien_v) |=> irq)
    else $error("interrupt missing for enabled flag");
  irq_drop_a: assert property (!(|(flag_v & ien_v)) |=> !irq)
    else $error("interrupt without enabled flag");
  ien_set_a: assert property (ien_set_s |=> (st_r.irq_enable & $past(wmd)) == ($past(wmd) & `UED_IEN_MASK))
    else $error("set alias did not enable");
  ien_clr_a: assert property (ien_clr_s |=> (st_r.irq_enable & $past(wmd)) == '0)
    else $error("clear alias did not disable");
  ien_cts_a: assert property (wr_fire && w_a == `UED_IEN_OFF && w_m[`UED_IEN_CTS_LOW_BIT]
                              |=> st_r.irq_enable[`UED_IEN_CTS_LOW_BIT] == $past(w_d[`UED_IEN_CTS_LOW_BIT]))
    else $error("clear-to-send enable not written");
  ien_rx_rdy_a: assert property (wr_fire && w_a == `UED_IEN_OFF && w_m[`UED_IEN_RX_RDY_BIT]
                                 |=> st_r.irq_enable[`UED_IEN_RX_RDY_BIT] == $past(w_d[`UED_IEN_RX_RDY_BIT]))
    else $error("received-byte enable not written");
  write_resp_a: assert property (wr_fire |=> wr_done_s)
    else $error("write answer late");
endmodule : ued_event_regs

// ==== bench/ued_event_src.sv ====
// stand-in for the serial engine and dma that raise the events
`timescale 1ns/1ns
module ued_event_src (
  // clock
  input wire logic aclk,
  // request from the bench
  input wire logic [8:0] fire,
  // event pulses to the bank
  output logic [8:0] ev
);
  // registered so each request reaches the bank one cycle later, as a clean pulse of the same length
  always_ff @(posedge aclk)
  begin
    ev <= fire;
  end
endmodule : ued_event_src

// ==== bench/tb_top.sv ====
// self-checking bench for the uart event register bank
`timescale 1ns/1ns
`include "ued_params.svh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_top;
  import ued_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, cts_n = 1;
  logic awrdy, wrdy, bv, arrdy, rv, beg_t, hlt_t, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] wd = 0, rdata, rnd = 32'h3b2b;
  ued_addr_t awa = 0, ara = 0;
  ued_chan_t pub;
  logic [8:0] fire = 0, ev;
  logic [33:0] expq[$];
  logic [1:0] bq[$];
  logic [33:0] exp_rd;
  logic [1:0] exp_wr;
  int error_cnt = 0, num_checks = 0;
  ued_addr_t evo[9] = '{12'h108, 12'h110, 12'h11c, 12'h120, 12'h124, 12'h144, 12'h14c,
    12'h150, 12'h158};
  ued_addr_t pubo[9] = '{12'h188, 12'h190, 12'h19c, 12'h1a0, 12'h1a4, 12'h1c4, 12'h1cc,
    12'h1d0, 12'h1d8};
  localparam logic [1:0] OK = `UED_RESP_OKAY;
  ued_event_src src (.aclk(aclk), .fire(fire), .ev(ev));
  ued_event_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
    .s_axi_awready(awrdy), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .rx_byte_ready_ev(ev[0]), .rx_buffer_full_ev(ev[1]), .tx_byte_sent_ev(ev[2]),
    .tx_done_ev(ev[3]), .fault_ev(ev[4]), .rx_timeout_ev(ev[5]), .rx_begun_ev(ev[6]),
    .tx_begun_ev(ev[7]), .tx_halted_ev(ev[8]), .flow_ctrl_n(cts_n), .pub_chan(pub),
    .rx_begin_task(beg_t), .rx_halt_task(hlt_t), .irq(irq));
  // free-running 100 MHz clock
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
  endfunction : lfsr
  task automatic wr(input ued_addr_t a, input logic [31:0] d, input logic [1:0] er);
    logic ra, rw, da, dw;
    da = 0;
    dw = 0;
    bq.push_back(er);
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= d;
    while (!(da && dw))
    begin
      @(negedge aclk);
      ra = awrdy & !da;
      rw = wrdy & !dw;
      @(posedge aclk);
      if (ra) begin awv <= 0; da = 1; end
      if (rw) begin wv <= 0; dw = 1; end
    end
    bry <= 1;
    do @(negedge aclk); while (!bv);
    @(posedge aclk);
    bry <= 0;
  endtask : wr
  // expectation is queued here and judged by the read monitor
  task automatic rd(input ued_addr_t a, input logic [33:0] e);
    arv <= 1;
    ara <= a;
    expq.push_back(e);
    do @(negedge aclk); while (!arrdy);
    @(posedge aclk);
    arv <= 0;
    rry <= 1;
    do @(negedge aclk); while (!rv);
    @(posedge aclk);
    rry <= 0;
  endtask : rd
  task automatic fire_ev(input int i, input ued_chan_t ep, input logic [1:0] et);
    fire <= 9'(1) << i;
    @(posedge aclk);
    fire <= 0;
    @(posedge aclk);
    @(negedge aclk);
    `CHK("pub_chan", ep, pub)
    `CHK("tasks", et, {hlt_t, beg_t})
    @(posedge aclk);
  endtask : fire_ev
  task automatic chk_irq(input logic e);
    @(negedge aclk);
    `CHK("irq", e, irq)
    @(posedge aclk);
  endtask : chk_irq
  // read and write monitor: oldest note against each accepted answer
  // each note is popped once, so a mismatch cannot shift the queue
  always @(posedge aclk)
  begin
    if (rv && rry)
    begin
      exp_rd = expq.pop_front();
      `CHK("read", exp_rd, {rresp, rdata})
    end
    if (bv && bry)
    begin
      exp_wr = bq.pop_front();
      `CHK("bresp", exp_wr, bresp)
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(12'h300, 0);
    rd(12'h200, 0);
    $display("test reset done");
    foreach (evo[i])
    begin
      rnd = lfsr(rnd);
      wr(pubo[i], rnd | 32'h8000_0000, OK);
      rd(pubo[i], {OK, 32'h8000_0000 | (rnd & 32'hf)});
      fire_ev(i, ued_chan_t'(1) << rnd[3:0], 2'b00);
      rd(evo[i], {OK, 32'h1});
      wr(pubo[i], rnd & 32'h7fff_ffff, OK);
      fire_ev(i, 0, 2'b00);
      wr(evo[i], 0, OK);
      rd(evo[i], {OK, 32'h0});
    end
    $display("test events done");
    for (int s = 0; s < 4; s++)
    begin
      wr(12'h200, s, OK);
      fire_ev(1, 0, s[1:0]);
    end
    wr(12'h304, 32'h10, OK);
    chk_irq(1);
    wr(12'h308, 32'h10, OK);
    chk_irq(0);
    rd(12'h300, 0);
    $display("test shortcut irq done");
    cts_n <= 0;
    wr(12'h300, 32'h1, OK);
    chk_irq(1);
    rd(12'h100, {OK, 32'h1});
    wr(12'h100, 0, OK);
    chk_irq(0);
    cts_n <= 1;
    wr(12'h300, 32'h2, OK);
    chk_irq(1);
    wr(12'h300, 32'h4, OK);
    chk_irq(0);
    fire_ev(0, 0, 2'b00);
    chk_irq(1);
    wr(12'h400, 32'h1, `UED_RESP_SLVERR);
    rd(12'h400, {`UED_RESP_SLVERR, 32'h0});
    wr(12'h310, 32'h0, OK);
    rd(12'h310, {OK, 32'h16});
    rd(12'h310, {OK, 32'h0});
    chk_irq(0);
    repeat (2) @(posedge aclk);
    $display("test flow control done");
    close_out();
  end
endmodule : tb_top
